// File: core/src_pkg.sv
// Purpose: shared constants and types of the system reset controller
// Assumes: core clock of 20 MHz (50 ns period)
// Notes: times are kept in their own unit, the power-on cycle count derives from them
package src_pkg;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int POR_DELAY_NS = 300000; // power_on_release_delay, longest figure
	localparam int POR_DELAY_CYC = POR_DELAY_NS / CLK_PERIOD_NS; // rounds down
	localparam int WDT_DIV = 12; // watchdog clock divider after reset
	localparam logic [3:0] WDT_DIV_LAST = 4'hb;
	localparam logic [1:0] PIN_GUARD = 2'h3; // cycles the pin sync needs to settle
	// ----------------------------------------
	// values after reset
	// ----------------------------------------
	localparam logic [7:0] PORT_RESET = 8'hff;
	localparam logic [15:0] PC_RESET = 16'h0000;
	// ----------------------------------------
	// states and causes
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_RUN = 3'b001,
		ST_HOLD = 3'b010,
		ST_DELAY = 3'b100
	} src_state_t;
	typedef enum logic [2:0] {
		CS_POR = 3'h0,
		CS_VDM = 3'h1,
		CS_PIN = 3'h2,
		CS_MCD = 3'h3,
		CS_SW = 3'h4
	} src_cause_t;
endpackage

// File: core/src_reset_ctrl.sv
// Purpose: gathers reset requests, holds core in reset, records last cause
// Assumes: i_sys_rst is the power-on request; pin, supply, one-shot are async
// Notes: pin is open drain, only ever driven low
`timescale 1ns/1ns
module src_reset_ctrl #(
	parameter int POR_DELAY_CYCLES = src_pkg::POR_DELAY_CYC
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	// reset pin, supply monitor, missing-clock one-shot (asynchronous)
	input wire logic i_rst_pin,
	output logic o_rst_pin_out,
	output logic o_rst_pin_oe,
	input wire logic i_supply_ok,
	input wire logic i_clk_oneshot_expired,
	// software writes from the core (same clock)
	input wire logic i_pin_flag_wr,
	input wire logic i_sw_reset_wr,
	input wire logic i_vdm_en_wr,
	input wire logic i_vdm_en_val,
	input wire logic i_vdm_sel_wr,
	input wire logic i_vdm_sel_val,
	input wire logic i_mcd_en_wr,
	input wire logic i_mcd_en_val,
	input wire logic i_wdt_disable,
	input wire logic i_port_wr,
	input wire logic [7:0] i_port_data,
	// core and peripheral control
	output logic o_core_rst,
	output logic o_irq_tmr_dis,
	output logic o_stack_reinit,
	output logic o_port_open_drain,
	output logic o_weak_pullup_en,
	output logic [7:0] o_port_latch,
	output logic o_clk_int_osc,
	output logic o_fetch_start,
	output logic [15:0] o_pc_value,
	output logic o_wdt_en,
	output logic o_wdt_tick,
	// cause flags, supply monitor state and clock detector enable
	output logic o_power_on_cause_flag,
	output logic o_pin_cause_flag,
	output logic o_missing_clock_cause_flag,
	output logic o_software_reset_force_flag,
	output logic o_supply_monitor_enable,
	output logic o_supply_sel,
	output logic o_mcd_en
);
	import src_pkg::*;

	// elaboration check: the delay counter is 16 bits wide and needs room to count
	if (POR_DELAY_CYCLES < 16 || POR_DELAY_CYCLES > 65535) begin : g_bad_delay
		$error("POR_DELAY_CYCLES out of range");
	end

	// ----------------------------------------
	// synchronisers
	// ----------------------------------------
	logic pin_s1, pin_s2, sup_s1, sup_s2, os_s1, os_s2;

	// two stages each; pin idles high so reset leaves it released
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			pin_s1 <= 1'b1;
			pin_s2 <= 1'b1;
			sup_s1 <= 1'b0;
			sup_s2 <= 1'b0;
			os_s1 <= 1'b0;
			os_s2 <= 1'b0;
		end else begin
			pin_s1 <= i_rst_pin;
			pin_s2 <= pin_s1;
			sup_s1 <= i_supply_ok;
			sup_s2 <= sup_s1;
			os_s1 <= i_clk_oneshot_expired;
			os_s2 <= os_s1;
		end
	end

	// ----------------------------------------
	// reset sequencer
	// ----------------------------------------
	src_state_t state, next_state;
	src_cause_t cause, next_cause;
	logic [15:0] dly, next_dly;
	logic [1:0] guard, next_guard;
	logic [3:0] wdiv, next_wdiv;
	logic [7:0] next_port;
	logic next_drive, next_fetch, next_wtick, next_wdt_en;
	logic next_por_f, next_pin_f, next_mcd_f, next_sw_f;
	logic next_vdm_en, next_vdm_sel, next_mcd_en;
	logic vdm_trip, pin_trip, mcd_trip, any_trip;

	// the pin is ignored while we drive it and until its echo clears the sync
	assign vdm_trip = o_supply_monitor_enable && o_supply_sel && !sup_s2;
	assign pin_trip = !pin_s2 && !o_rst_pin_oe && (guard == 2'h0);
	assign mcd_trip = o_mcd_en && os_s2;
	assign any_trip = i_pin_flag_wr || vdm_trip || pin_trip || mcd_trip || i_sw_reset_wr;

	always_comb begin
		next_state = state;
		next_cause = cause;
		next_dly = dly;
		next_guard = (guard != 2'h0) ? guard - 2'h1 : guard;
		next_port = o_port_latch;
		next_fetch = 1'b0;
		next_wdt_en = o_wdt_en;
		next_por_f = o_power_on_cause_flag;
		next_pin_f = o_pin_cause_flag;
		next_mcd_f = o_missing_clock_cause_flag;
		next_sw_f = o_software_reset_force_flag;
		next_vdm_en = o_supply_monitor_enable;
		next_vdm_sel = o_supply_sel;
		next_mcd_en = o_mcd_en;
		case (state)
			ST_RUN: begin
				if (any_trip) begin
					// priority: forced power-on, supply, pin, clock, software
					if (i_pin_flag_wr) begin
						next_cause = CS_POR;
					end else if (vdm_trip) begin
						next_cause = CS_VDM;
					end else if (pin_trip) begin
						next_cause = CS_PIN;
					end else if (mcd_trip) begin
						next_cause = CS_MCD;
					end else begin
						next_cause = CS_SW;
					end
					next_state = ST_HOLD;
				end else begin
					if (i_vdm_en_wr) begin
						next_vdm_en = i_vdm_en_val;
					end
					if (i_vdm_sel_wr) begin
						next_vdm_sel = i_vdm_sel_val;
					end
					if (i_mcd_en_wr) begin
						next_mcd_en = i_mcd_en_val;
					end
					if (i_wdt_disable) begin
						next_wdt_en = 1'b0;
					end
					if (i_port_wr) begin
						next_port = i_port_data;
					end
				end
			end
			ST_HOLD: begin
				// release once the holding source has gone away; power-on moves to the delay instead
				case (cause)
					CS_POR: begin
						if (sup_s2) begin
							next_state = ST_DELAY;
							next_dly = 16'h0000;
						end
					end
					CS_VDM: begin
						if (sup_s2) begin
							next_state = ST_RUN;
						end
					end
					CS_PIN: begin
						if (pin_s2) begin
							next_state = ST_RUN;
						end
					end
					CS_MCD: begin
						if (!os_s2) begin
							next_state = ST_RUN;
						end
					end
					default: begin
						next_state = ST_RUN;
					end
				endcase
			end
			ST_DELAY: begin
				if (!sup_s2) begin
					next_state = ST_HOLD; // supply dipped again, restart
				end else if (dly == 16'(POR_DELAY_CYCLES - 1)) begin
					next_state = ST_RUN;
				end else begin
					next_dly = dly + 16'h0001;
				end
			end
			default: begin
				next_state = ST_HOLD;
				next_cause = CS_POR;
			end
		endcase
		// reset state forces defaults; flags follow the captured cause
		if (next_state != ST_RUN) begin
			next_port = PORT_RESET;
			next_wdt_en = 1'b0;
			next_vdm_sel = 1'b0;
			next_mcd_en = 1'b0;
			next_por_f = (next_cause == CS_POR) || (next_cause == CS_VDM);
			next_pin_f = (next_cause == CS_PIN);
			next_mcd_f = (next_cause == CS_MCD);
			next_sw_f = (next_cause == CS_SW);
			if (next_cause == CS_POR) begin
				next_vdm_en = 1'b1;
			end
		end
		// leaving reset restarts the core
		if (state != ST_RUN && next_state == ST_RUN) begin
			next_fetch = 1'b1;
			next_wdt_en = 1'b1;
		end
		next_drive = (next_state != ST_RUN) && (next_cause == CS_POR || next_cause == CS_VDM);
		if (o_rst_pin_oe && !next_drive) begin
			next_guard = PIN_GUARD;
		end
		// watchdog clock divider, restarted with the watchdog
		next_wtick = 1'b0;
		if (!next_wdt_en || !o_wdt_en || wdiv == WDT_DIV_LAST) begin
			next_wdiv = 4'h0;
			next_wtick = next_wdt_en && o_wdt_en;
		end else begin
			next_wdiv = wdiv + 4'h1;
		end
	end

	// register the sequencer; i_sys_rst is a power-on request
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			state <= ST_HOLD;
			cause <= CS_POR;
			dly <= 16'h0000;
			guard <= 2'h0;
			wdiv <= 4'h0;
			o_port_latch <= PORT_RESET;
			o_rst_pin_oe <= 1'b1;
			o_fetch_start <= 1'b0;
			o_wdt_en <= 1'b0;
			o_wdt_tick <= 1'b0;
			o_power_on_cause_flag <= 1'b1;
			o_pin_cause_flag <= 1'b0;
			o_missing_clock_cause_flag <= 1'b0;
			o_software_reset_force_flag <= 1'b0;
			o_supply_monitor_enable <= 1'b1;
			o_supply_sel <= 1'b0;
			o_mcd_en <= 1'b0;
		end else begin
			state <= next_state;
			cause <= next_cause;
			dly <= next_dly;
			guard <= next_guard;
			wdiv <= next_wdiv;
			o_port_latch <= next_port;
			o_rst_pin_oe <= next_drive;
			o_fetch_start <= next_fetch;
			o_wdt_en <= next_wdt_en;
			o_wdt_tick <= next_wtick;
			o_power_on_cause_flag <= next_por_f;
			o_pin_cause_flag <= next_pin_f;
			o_missing_clock_cause_flag <= next_mcd_f;
			o_software_reset_force_flag <= next_sw_f;
			o_supply_monitor_enable <= next_vdm_en;
			o_supply_sel <= next_vdm_sel;
			o_mcd_en <= next_mcd_en;
		end
	end

	// core-facing levels; memory has no clear path, only the stack pointer reloads
	assign o_core_rst = (state != ST_RUN);
	assign o_irq_tmr_dis = o_core_rst;
	assign o_stack_reinit = o_core_rst;
	assign o_port_open_drain = o_core_rst;
	assign o_weak_pullup_en = 1'b1;
	assign o_clk_int_osc = o_core_rst || o_fetch_start;
	assign o_pc_value = PC_RESET;
	assign o_rst_pin_out = 1'b0;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_sys_rst);

	// helper for the delay check: cycles spent in the current delay stretch
	logic [15:0] delay_run, next_delay_run;
	always_comb begin
		next_delay_run = (state == ST_DELAY) ? delay_run + 16'h0001 : 16'h0000;
	end
	always_ff @(posedge i_core_clk) begin
		delay_run <= i_sys_rst ? 16'h0000 : next_delay_run;
	end

	property p_hold_defaults;
		o_core_rst |-> o_irq_tmr_dis && !o_wdt_en && o_stack_reinit;
	endproperty
	a_hold_defaults: assert property (p_hold_defaults) else $error("defaults not held");
	property p_port_ones;
		o_core_rst |-> o_port_latch == PORT_RESET && o_port_open_drain;
	endproperty
	a_port_ones: assert property (p_port_ones) else $error("port latch not all ones");
	property p_pin_drive;
		o_core_rst && (cause == CS_POR || cause == CS_VDM) |-> o_rst_pin_oe;
	endproperty
	a_pin_drive: assert property (p_pin_drive) else $error("reset pin not driven");
	property p_exit;
		$fell(o_core_rst) |-> o_fetch_start && o_clk_int_osc && o_wdt_en;
	endproperty
	a_exit: assert property (p_exit) else $error("bad restart sequence");
	// first tick twelve cycles after exit, unless a reset or a disable cuts in
	property p_wdt_first_tick;
		$fell(o_core_rst) ##1 (!o_core_rst && o_wdt_en) [*8]
			##1 (!o_core_rst && o_wdt_en) [*4] |-> o_wdt_tick;
	endproperty
	a_wdt_first_tick: assert property (p_wdt_first_tick) else $error("watchdog tick late");
	// a delay stretch that ends in release must have run its full length
	property p_delay;
		state == ST_RUN && delay_run != 16'h0000 |-> delay_run == 16'(POR_DELAY_CYCLES);
	endproperty
	a_delay: assert property (p_delay) else $error("power-on delay too short");
	property p_por_flag;
		$fell(o_core_rst) |-> o_power_on_cause_flag == (cause == CS_POR || cause == CS_VDM);
	endproperty
	a_por_flag: assert property (p_por_flag) else $error("power-on flag wrong");
	property p_vdm_keep;
		o_core_rst && cause != CS_POR |=> $stable(o_supply_monitor_enable);
	endproperty
	a_vdm_keep: assert property (p_vdm_keep) else $error("monitor enable changed");
	property p_forced_por;
		!o_core_rst && i_pin_flag_wr |=> o_core_rst && cause == CS_POR && o_rst_pin_oe;
	endproperty
	a_forced_por: assert property (p_forced_por) else $error("forced power-on lost");
	property p_supply;
		!o_core_rst && vdm_trip && !i_pin_flag_wr |=> o_core_rst && o_rst_pin_oe;
	endproperty
	a_supply: assert property (p_supply) else $error("supply reset missed");
	property p_sw;
		!o_core_rst && i_sw_reset_wr && !i_pin_flag_wr && !vdm_trip && !pin_trip && !mcd_trip
			|=> (o_core_rst && o_software_reset_force_flag)
			##1 (!o_core_rst && o_software_reset_force_flag);
	endproperty
	a_sw: assert property (p_sw) else $error("software reset missed");
	property p_flags_stable;
		!o_core_rst ##1 !o_core_rst |-> $stable(o_pin_cause_flag)
			&& $stable(o_missing_clock_cause_flag) && $stable(o_power_on_cause_flag)
			&& $stable(o_software_reset_force_flag);
	endproperty
	a_flags_stable: assert property (p_flags_stable) else $error("cause flag moved");

	c_pin_reset: cover property (!o_core_rst && pin_trip ##1 o_core_rst ##[1:20] !o_core_rst);
	c_mcd_reset: cover property ($fell(o_core_rst) && o_missing_clock_cause_flag);
	c_por_release: cover property ($fell(o_core_rst) && o_power_on_cause_flag);
endmodule

// File: tb/src_core_model.sv
// Purpose: behavioural stand-in for the core that the reset block holds
// Assumes: one clock, pc and memory only move while o_core_rst is low
// Notes: memory byte is never touched by reset, only the stack pointer is
`timescale 1ns/1ns
module src_core_model #(
	parameter logic [7:0] SP_INIT = 8'h07
) (
	// clock
	input wire logic i_core_clk,
	// controls from the reset block
	input wire logic i_halt,
	input wire logic i_stack_reinit,
	input wire logic i_fetch_start,
	input wire logic [15:0] i_pc_value,
	// software side
	input wire logic i_mem_wr,
	input wire logic [7:0] i_mem_data,
	// observed core state
	output logic [15:0] o_pc,
	output logic [7:0] o_sp,
	output logic [7:0] o_mem
);
	// ----------------------------------------
	// core state
	// ----------------------------------------
	// halted core freezes pc; stack pointer reloads, memory kept
	always_ff @(posedge i_core_clk) begin
		if (i_fetch_start) begin
			o_pc <= i_pc_value;
		end else if (!i_halt) begin
			o_pc <= o_pc + 16'h0001;
		end
		if (i_stack_reinit) begin
			o_sp <= SP_INIT;
		end
		if (i_mem_wr && !i_halt) begin
			o_mem <= i_mem_data;
		end
	end
endmodule

// File: tb/tb_system_reset_controller.sv
// Purpose: self-checking bench for the reset controller
// Assumes: 50 ns clock, inputs driven 5 ns after each rising edge
// Notes: power-on delay shortened to 16 cycles to keep the run short
`timescale 1ns/1ns
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_errors++; \
	$display("wrong value at %0t: got %0h expected %0h", $time, got, exp); end end
module tb_system_reset_controller;
	import src_pkg::*;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	localparam int POR_D = 16;
	logic clk = 1'b0, rst = 1'b1, pin_low = 1'b0, sup_ok = 1'b1, osx = 1'b0;
	logic [6:0] wr = '0;
	logic vdm_v = 1'b0, sel_v = 1'b0, mcd_v = 1'b0, mem_wr = 1'b0;
	logic [7:0] pdat = 8'h00, mdat = 8'h00;
	logic pin_out, pin_oe, core_rst, irq_dis, stk, od, pu, osc, fetch, wdt_en, tick;
	logic f_por, f_pin, f_mcd, f_sw, vdm_en, vdm_sel, mcd_en;
	logic [7:0] port;
	logic [15:0] pc, m_pc;
	logic [7:0] m_sp, m_mem;
	int n_errors = 0, checks_done = 0, n;
	// pull-up on the pin; device only ever pulls it low
	wire logic pin_wire = (pin_low || (pin_oe && !pin_out)) ? 1'b0 : 1'b1;
	always #25 clk = ~clk;
	// ----------------------------------------
	// design and core model
	// ----------------------------------------
	src_reset_ctrl #(.POR_DELAY_CYCLES(POR_D)) uut (.i_core_clk(clk), .i_sys_rst(rst),
		.i_rst_pin(pin_wire), .o_rst_pin_out(pin_out), .o_rst_pin_oe(pin_oe),
		.i_supply_ok(sup_ok), .i_clk_oneshot_expired(osx), .i_pin_flag_wr(wr[0]),
		.i_sw_reset_wr(wr[1]), .i_vdm_en_wr(wr[2]), .i_vdm_en_val(vdm_v),
		.i_vdm_sel_wr(wr[3]), .i_vdm_sel_val(sel_v), .i_mcd_en_wr(wr[4]),
		.i_mcd_en_val(mcd_v), .i_wdt_disable(wr[5]), .i_port_wr(wr[6]),
		.i_port_data(pdat), .o_core_rst(core_rst), .o_irq_tmr_dis(irq_dis),
		.o_stack_reinit(stk), .o_port_open_drain(od), .o_weak_pullup_en(pu),
		.o_port_latch(port), .o_clk_int_osc(osc), .o_fetch_start(fetch),
		.o_pc_value(pc), .o_wdt_en(wdt_en), .o_wdt_tick(tick),
		.o_power_on_cause_flag(f_por), .o_pin_cause_flag(f_pin),
		.o_missing_clock_cause_flag(f_mcd), .o_software_reset_force_flag(f_sw),
		.o_supply_monitor_enable(vdm_en), .o_supply_sel(vdm_sel), .o_mcd_en(mcd_en));
	src_core_model core (.i_core_clk(clk), .i_halt(core_rst), .i_stack_reinit(stk),
		.i_fetch_start(fetch), .i_pc_value(pc), .i_mem_wr(mem_wr), .i_mem_data(mdat),
		.o_pc(m_pc), .o_sp(m_sp), .o_mem(m_mem));
	// ----------------------------------------
	// access tasks
	// ----------------------------------------
	task automatic step(input int k = 1);
		repeat (k) begin
			@(posedge clk);
			#5;
		end
	endtask
	// one-cycle write strobe, index selects which register bit
	task automatic pulse(input int idx);
		wr[idx] = 1'b1;
		step();
		wr[idx] = 1'b0;
	endtask
	// bounded wait for first cycle out of reset, n counts cycles
	task automatic wait_fetch();
		n = 0;
		while (fetch !== 1'b1 && n < 2000) begin
			step();
			n++;
		end
		if (n >= 2000) begin
			n_errors++;
			tally_and_finish();
		end
		`CHK(core_rst, 1'b0)
		`CHK(pc, PC_RESET)
		`CHK(osc, 1'b1)
		`CHK(wdt_en, 1'b1)
		`CHK({irq_dis, stk, od, pu, pin_out}, 5'h02)
		step();
		`CHK(m_pc, PC_RESET)
	endtask
	// bounded wait for the next watchdog tick, n counts cycles
	task automatic wait_tick();
		while (tick !== 1'b1 && n < 40) begin
			step();
			n++;
		end
		if (n >= 40) begin
			n_errors++;
			tally_and_finish();
		end
	endtask
	// state forced while the core is held
	task automatic chk_held();
		`CHK({core_rst, irq_dis, stk, od, pu, osc}, 6'h3f)
		`CHK(port, PORT_RESET)
	endtask
	task automatic chk_flags(input logic [3:0] e);
		`CHK({f_por, f_pin, f_mcd, f_sw}, e)
	endtask
	task automatic end_test(input string s);
		$display("test %s done", s);
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// ----------------------------------------
	// test sequence
	// ----------------------------------------
	initial begin
		step(10);
		chk_held();
		`CHK(pin_oe, 1'b1)
		rst = 1'b0;
		wait_fetch();
		`CHK(n >= POR_D, 1'b1)
		`CHK(pin_oe, 1'b0)
		chk_flags(4'h8);
		`CHK(vdm_en, 1'b1)
		n = 0;
		wait_tick();
		step();
		n = 1;
		wait_tick();
		`CHK(n, WDT_DIV)
		pulse(5);
		`CHK(wdt_en, 1'b0)
		end_test("power on");
		// software reset keeps memory and monitor enable, resets port
		mem_wr = 1'b1;
		mdat = 8'h3c;
		pdat = 8'h5a;
		pulse(6);
		mem_wr = 1'b0;
		`CHK(port, 8'h5a)
		vdm_v = 1'b0;
		pulse(2);
		pulse(1);
		chk_held();
		`CHK(pin_oe, 1'b0)
		`CHK(m_mem, 8'h3c)
		wait_fetch();
		chk_flags(4'h1);
		`CHK(vdm_en, 1'b0)
		`CHK(m_sp, 8'h07)
		end_test("software");
		// external pin pulled low
		pin_low = 1'b1;
		step(5);
		chk_held();
		pulse(1);
		`CHK(f_sw, 1'b0)
		pin_low = 1'b0;
		wait_fetch();
		chk_flags(4'h4);
		end_test("pin");
		// missing clock detector
		mcd_v = 1'b1;
		pulse(4);
		`CHK(mcd_en, 1'b1)
		osx = 1'b1;
		step(5);
		`CHK(core_rst, 1'b1)
		`CHK(pin_oe, 1'b0)
		osx = 1'b0;
		wait_fetch();
		chk_flags(4'h2);
		step(20);
		chk_flags(4'h2);
		end_test("missing clock");
		// enable monitor, let it settle, then select it
		vdm_v = 1'b1;
		pulse(2);
		step(4);
		sel_v = 1'b1;
		pulse(3);
		`CHK(vdm_sel, 1'b1)
		sup_ok = 1'b0;
		step(6);
		chk_held();
		`CHK(pin_oe, 1'b1)
		sup_ok = 1'b1;
		wait_fetch();
		chk_flags(4'h8);
		`CHK(pin_oe, 1'b0)
		end_test("supply");
		// software forced power-on
		pulse(0);
		`CHK(pin_oe, 1'b1)
		wait_fetch();
		`CHK(n >= POR_D, 1'b1)
		chk_flags(4'h8);
		`CHK(vdm_en, 1'b1)
		end_test("forced power on");
		// power-on request in mid-run restores monitor enable and flags
		vdm_v = 1'b0;
		pulse(2);
		`CHK(vdm_en, 1'b0)
		rst = 1'b1;
		step(2);
		chk_held();
		`CHK(pin_oe, 1'b1)
		`CHK(vdm_en, 1'b1)
		rst = 1'b0;
		wait_fetch();
		`CHK(n >= POR_D, 1'b1)
		chk_flags(4'h8);
		end_test("mid-run power on");
		tally_and_finish();
	end
endmodule
